/* src/tile_dbg_pkg.sv */
package tile_dbg_pkg;
    localparam int WATCH_COUNT = 4;
    localparam int CORE_COUNT = 8;

    // Register numbers in the tile configuration space
    localparam logic [7:0] OFS_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_COUNTS_A = 8'h01;
    localparam logic [7:0] OFS_COUNTS_B = 8'h02;
    localparam logic [7:0] OFS_WRITE_PROTECT = 8'h04;
    localparam logic [7:0] OFS_IRQ_REQUEST = 8'h05;
    localparam logic [7:0] OFS_CLOCK_DIVIDER = 8'h06;
    localparam logic [7:0] OFS_SECURITY = 8'h07;
    localparam logic [7:0] OFS_SCRATCH = 8'h20;
    localparam logic [7:0] OFS_PC_SNAP = 8'h40;
    localparam logic [7:0] OFS_SR_SNAP = 8'h60;
    localparam logic [7:0] OFS_DATA_WATCH_CTRL = 8'h70;
    localparam logic [7:0] OFS_RES_WATCH_MASK = 8'h80;
    localparam logic [7:0] OFS_RES_WATCH_VALUE = 8'h90;
    localparam logic [7:0] OFS_RES_WATCH_CTRL = 8'h9C;
    localparam logic [7:0] OFS_IRQ_TYPE = 8'h15;
    localparam logic [7:0] OFS_IRQ_DATA = 8'h16;

    // Watch control fields
    localparam int WC_ENABLE_BIT = 0;
    localparam int WC_COND_BIT = 1;
    localparam int WC_LOAD_BIT = 2;
    localparam int WC_THREAD_LSB = 16;
    localparam logic [31:0] DATA_WATCH_CTRL_MASK = 32'h00FF0007;
    localparam logic [31:0] RES_WATCH_CTRL_MASK = 32'h00FF0003;

    // Configuration fields
    localparam int WP_ALL_BIT = 31;
    localparam int WP_SWITCH_BIT = 0;
    localparam logic [31:0] WRITE_PROTECT_MASK = 32'h80000001;
    localparam int IRQ_REQ_BIT = 0;
    localparam int IRQ_DEBUG_MODE_BIT = 1;
    localparam int CLK_STOP_BIT = 31;
    localparam logic [31:0] CLOCK_DIVIDER_MASK = 32'h8000FFFF;
    localparam logic [31:0] COUNTS_A_MASK = 32'hFFFFFF00;
    localparam logic [31:0] COUNTS_B_MASK = 32'h0000FFFF;
    localparam logic [31:0] IRQ_TYPE_MASK = 32'h0003FF07;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;

    // Debug interrupt cause codes
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_HOST = 3'h1;
    localparam logic [2:0] CAUSE_CALL = 3'h2;
    localparam logic [2:0] CAUSE_IBREAK = 3'h3;
    localparam logic [2:0] CAUSE_DATA_WATCH = 3'h4;
    localparam logic [2:0] CAUSE_RES_WATCH = 3'h5;

    typedef enum logic [1:0] {
        SRC_SWITCH,
        SRC_CORE,
        SRC_TEST_PORT
    } access_source_t;

    typedef struct packed {
        logic valid;
        logic write;
        access_source_t source;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic valid;
        logic is_load;
        logic [2:0] thread;
        logic cond_a;
        logic cond_b;
        logic [31:0] address;
    } data_access_t;

    typedef struct packed {
        logic valid;
        logic [2:0] thread;
        logic [31:0] resource_id;
    } res_access_t;
endpackage

/* src/tile_debug_config_registers.sv */
// Operation
// - Watch control bits 23:16 are per-thread enables, reset 0, gating hits
// - Watch control bit 0 enables the watchpoint; cleared means no interrupt
// - Data watch control bit 2 makes the watchpoint trigger on loads too
// - Data watch bit 1: 0 needs A and B, 1 needs A or B
// - Four data watch control registers at 0x70 through 0x73
// - Four writable resource watch mask registers at 0x80 through 0x83
// - Four resource watch value registers at 0x90 through 0x93
// - Resource watch control bit 1 picks condition A or B, reset 0
// - Identity register: processor id, node, revision, version; read-only
// - Count register A: channel ends, locks, synchronisers; bits 7:0 reserved
// - Count register B: clock blocks 15:8, timers 7:0, upper reserved
// - Protect bit 31 makes debug registers read-only from every source
// - Protect bit 0 makes debug registers read-only from the switch only
// - Writing 1 to 0x05 bit 0 requests a processor debug interrupt
// - Bit 1 of 0x05 reads 1 while the processor is in debug mode
// - Clock divider bits 15:0, reset 0, divide the PLL clock
// - Divider bit 31 set stops the tile clock entirely
// - Core program counter and status snapshots readable at 0x40 and 0x60
// - Interrupt type holds a 3-bit cause code, 1 to 5
// - Interrupt data records address on data hit, resource id on resource hit
module tile_debug_config_registers
    import tile_dbg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pll_clk_tick,
    input wire cfg_req_t cfg_req,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic [31:0] identity_value,
    input wire logic [31:0] counts_a_value,
    input wire logic [31:0] counts_b_value,
    input wire logic [31:0] security_value,
    input wire logic [CORE_COUNT*32-1:0] core_pc_flat,
    input wire logic [CORE_COUNT*32-1:0] core_sr_flat,
    input wire logic debug_mode,
    input wire data_access_t data_access,
    input wire res_access_t res_access,
    input wire logic res_cond_a,
    input wire logic res_cond_b,
    output logic debug_irq,
    output logic [2:0] irq_cause,
    output logic [31:0] irq_data,
    output logic tile_clk_en
);
    logic [31:0] data_ctrl_reg [WATCH_COUNT];
    logic [31:0] res_mask_reg [WATCH_COUNT];
    logic [31:0] res_value_reg [WATCH_COUNT];
    logic [31:0] res_ctrl_reg [WATCH_COUNT];
    logic [31:0] scratch_reg [CORE_COUNT];
    logic [31:0] protect_reg;
    logic irq_req_reg;
    logic [31:0] divider_reg;
    logic [15:0] div_count_reg;
    logic [2:0] cause_reg;
    logic [31:0] data_reg;
    logic irq_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic clk_en_reg;
    logic [WATCH_COUNT-1:0] data_hit;
    logic [WATCH_COUNT-1:0] res_hit;
    logic wr;
    logic wr_allowed;

    assign wr = cfg_req.valid && cfg_req.write;
    // Switch-only protection leaves the core and test port writable
    assign wr_allowed = wr && !protect_reg[WP_ALL_BIT]
        && !(protect_reg[WP_SWITCH_BIT] && cfg_req.source == SRC_SWITCH);

    genvar gi;
    generate
        for (gi = 0; gi < WATCH_COUNT; gi++) begin : g_watch
            logic [7:0] d_ofs;
            logic [7:0] m_ofs;
            logic [7:0] v_ofs;
            logic [7:0] c_ofs;
            logic d_cond;
            logic d_kind;
            logic r_match;
            assign d_ofs = OFS_DATA_WATCH_CTRL + 8'(gi);
            assign m_ofs = OFS_RES_WATCH_MASK + 8'(gi);
            assign v_ofs = OFS_RES_WATCH_VALUE + 8'(gi);
            assign c_ofs = OFS_RES_WATCH_CTRL + 8'(gi);
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    data_ctrl_reg[gi] <= ZERO_WORD;
                    res_mask_reg[gi] <= ZERO_WORD;
                    res_value_reg[gi] <= ZERO_WORD;
                    res_ctrl_reg[gi] <= ZERO_WORD;
                end else if (wr_allowed) begin
                    if (cfg_req.addr == d_ofs) begin
                        data_ctrl_reg[gi] <= cfg_req.wdata & DATA_WATCH_CTRL_MASK;
                    end
                    if (cfg_req.addr == m_ofs) begin
                        res_mask_reg[gi] <= cfg_req.wdata;
                    end
                    if (cfg_req.addr == v_ofs) begin
                        res_value_reg[gi] <= cfg_req.wdata;
                    end
                    if (cfg_req.addr == c_ofs) begin
                        res_ctrl_reg[gi] <= cfg_req.wdata & RES_WATCH_CTRL_MASK;
                    end
                end
            end
            // Stores always qualify; loads only with the load bit
            assign d_kind = !data_access.is_load || data_ctrl_reg[gi][WC_LOAD_BIT];
            assign d_cond = data_ctrl_reg[gi][WC_COND_BIT]
                ? (data_access.cond_a || data_access.cond_b)
                : (data_access.cond_a && data_access.cond_b);
            assign data_hit[gi] = data_access.valid && data_ctrl_reg[gi][WC_ENABLE_BIT]
                && data_ctrl_reg[gi][WC_THREAD_LSB + 32'(data_access.thread)]
                && d_kind && d_cond;
            assign r_match = ((res_access.resource_id & res_mask_reg[gi])
                == (res_value_reg[gi] & res_mask_reg[gi]))
                && (res_ctrl_reg[gi][WC_COND_BIT] ? res_cond_b : res_cond_a);
            assign res_hit[gi] = res_access.valid && res_ctrl_reg[gi][WC_ENABLE_BIT]
                && res_ctrl_reg[gi][WC_THREAD_LSB + 32'(res_access.thread)]
                && r_match;
        end
        for (gi = 0; gi < CORE_COUNT; gi++) begin : g_scratch
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    scratch_reg[gi] <= ZERO_WORD;
                end else if (wr_allowed && cfg_req.addr == OFS_SCRATCH + 8'(gi)) begin
                    scratch_reg[gi] <= cfg_req.wdata;
                end
            end
        end
    endgenerate

    // The protect register itself is never locked, or it could not be undone
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            protect_reg <= ZERO_WORD;
        end else if (wr && cfg_req.addr == OFS_WRITE_PROTECT) begin
            protect_reg <= cfg_req.wdata & WRITE_PROTECT_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_req_reg <= 1'b0;
            divider_reg <= ZERO_WORD;
        end else if (wr_allowed && cfg_req.addr == OFS_IRQ_REQUEST) begin
            irq_req_reg <= cfg_req.wdata[IRQ_REQ_BIT];
        end else if (wr_allowed && cfg_req.addr == OFS_CLOCK_DIVIDER) begin
            divider_reg <= cfg_req.wdata & CLOCK_DIVIDER_MASK;
        end else if (irq_req_reg && !debug_mode && cause_reg == CAUSE_NONE) begin
            irq_req_reg <= irq_req_reg;
        end else if (debug_mode) begin
            // Request consumed once the processor has entered debug mode
            irq_req_reg <= 1'b0;
        end
    end

    // Divide value 0 or 1 passes every PLL tick
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_count_reg <= 16'h0000;
            clk_en_reg <= 1'b0;
        end else if (divider_reg[CLK_STOP_BIT]) begin
            div_count_reg <= 16'h0000;
            clk_en_reg <= 1'b0;
        end else if (pll_clk_tick) begin
            if (div_count_reg + 16'h0001 >= divider_reg[15:0]) begin
                div_count_reg <= 16'h0000;
                clk_en_reg <= 1'b1;
            end else begin
                div_count_reg <= div_count_reg + 16'h0001;
                clk_en_reg <= 1'b0;
            end
        end else begin
            clk_en_reg <= 1'b0;
        end
    end

    // Cause capture; any watchpoint hit counts alike, data before resource before host request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cause_reg <= CAUSE_NONE;
            data_reg <= ZERO_WORD;
            irq_reg <= 1'b0;
        end else if (debug_mode) begin
            irq_reg <= 1'b0;
        end else if (|data_hit) begin
            cause_reg <= CAUSE_DATA_WATCH;
            data_reg <= data_access.address;
            irq_reg <= 1'b1;
        end else if (|res_hit) begin
            cause_reg <= CAUSE_RES_WATCH;
            data_reg <= res_access.resource_id;
            irq_reg <= 1'b1;
        end else if (irq_req_reg) begin
            cause_reg <= CAUSE_HOST;
            irq_reg <= 1'b1;
        end
    end

    // Read path: one-cycle registered answer to every request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
            rdata_reg <= ZERO_WORD;
        end else begin
            ack_reg <= cfg_req.valid;
            rdata_reg <= ZERO_WORD;
            if (cfg_req.valid && !cfg_req.write) begin
                unique casez (cfg_req.addr)
                    OFS_IDENTITY: rdata_reg <= identity_value;
                    OFS_COUNTS_A: rdata_reg <= counts_a_value & COUNTS_A_MASK;
                    OFS_COUNTS_B: rdata_reg <= counts_b_value & COUNTS_B_MASK;
                    OFS_WRITE_PROTECT: rdata_reg <= protect_reg;
                    OFS_IRQ_REQUEST: rdata_reg <= {30'h0, debug_mode, irq_req_reg};
                    OFS_CLOCK_DIVIDER: rdata_reg <= divider_reg;
                    OFS_SECURITY: rdata_reg <= security_value;
                    OFS_IRQ_TYPE: rdata_reg <= {29'h0, cause_reg};
                    OFS_IRQ_DATA: rdata_reg <= data_reg;
                    8'b0010_0???: rdata_reg <= scratch_reg[cfg_req.addr[2:0]];
                    8'b0100_0???: rdata_reg <= core_pc_flat[32*cfg_req.addr[2:0] +: 32];
                    8'b0110_0???: rdata_reg <= core_sr_flat[32*cfg_req.addr[2:0] +: 32];
                    8'b0111_00??: rdata_reg <= data_ctrl_reg[cfg_req.addr[1:0]];
                    8'b1000_00??: rdata_reg <= res_mask_reg[cfg_req.addr[1:0]];
                    8'b1001_00??: rdata_reg <= res_value_reg[cfg_req.addr[1:0]];
                    8'b1001_11??: rdata_reg <= res_ctrl_reg[cfg_req.addr[1:0]];
                    default: rdata_reg <= ZERO_WORD;
                endcase
            end
        end
    end

    assign cfg_ack = ack_reg;
    assign cfg_rdata = rdata_reg;
    assign debug_irq = irq_reg;
    assign irq_cause = cause_reg;
    assign irq_data = data_reg;
    assign tile_clk_en = clk_en_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    disabled_watch_quiet_a: assert property (
        (data_access.valid && !(|(data_hit | res_hit)) && !irq_req_reg && !debug_mode
            && !irq_reg) |=> !irq_reg)
        else $error("interrupt raised with no enabled hit");
    data_hit_cause_a: assert property (
        (data_hit != 0 && !debug_mode) |=> (irq_cause == CAUSE_DATA_WATCH
            && irq_data == $past(data_access.address) && debug_irq))
        else $error("data hit not recorded");
    res_hit_cause_a: assert property (
        (res_hit != 0 && data_hit == 0 && !debug_mode) |=> (irq_cause == CAUSE_RES_WATCH))
        else $error("resource hit cause wrong");
    protect_all_a: assert property (
        (protect_reg[WP_ALL_BIT] && wr && cfg_req.addr == OFS_CLOCK_DIVIDER)
            |=> $stable(divider_reg))
        else $error("protected register changed");
    protect_switch_a: assert property (
        (protect_reg[WP_SWITCH_BIT] && wr && cfg_req.source == SRC_SWITCH
            && cfg_req.addr == OFS_SCRATCH) |=> $stable(scratch_reg[0]))
        else $error("switch write not blocked");
    clock_stop_a: assert property (
        divider_reg[CLK_STOP_BIT] |=> !tile_clk_en)
        else $error("tile clock runs while stopped");
    read_answer_a: assert property (
        cfg_req.valid |=> cfg_ack ##1 (!cfg_ack || $past(cfg_req.valid)))
        else $error("configuration answer missing");
    debug_mode_read_a: assert property (
        (cfg_req.valid && !cfg_req.write && cfg_req.addr == OFS_IRQ_REQUEST)
            |=> cfg_rdata[IRQ_DEBUG_MODE_BIT] == $past(debug_mode))
        else $error("debug mode bit misread");
    reserved_zero_a: assert property (
        (cfg_req.valid && !cfg_req.write && cfg_req.addr == OFS_COUNTS_A)
            |=> cfg_rdata[7:0] == 8'h00)
        else $error("reserved bits nonzero");

    data_hit_c: cover property (data_hit != 0);
    res_hit_c: cover property (res_hit != 0);
    host_irq_c: cover property (irq_req_reg ##1 debug_irq);
    clock_stop_c: cover property (divider_reg[CLK_STOP_BIT]);
endmodule

/* test/cfg_host.sv */
module cfg_host
    import tile_dbg_pkg::*;
(
    input wire logic clk,
    output cfg_req_t req,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_ok;
    initial req = '0;
    // Released address and data carry the inverse so a stale value can never pass for a fresh one
    task automatic xfer(input logic wr, input access_source_t s, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        @(negedge clk);
        req <= '{1'b1, wr, s, a, d};
        @(negedge clk);
        ack_ok = cfg_ack;
        rd = cfg_rdata;
        req <= '{1'b0, 1'b0, s, ~a, ~d};
    endtask
endmodule

/* test/tile_debug_config_registers_bench.sv */
module tile_debug_config_registers_bench;
    import tile_dbg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tick = 1'b0;
    logic dbg = 1'b0;
    logic rca = 1'b0;
    logic rcb = 1'b0;
    logic e;
    cfg_req_t cfg_req;
    logic cfg_ack, debug_irq, tile_clk_en;
    logic [2:0] irq_cause;
    logic [31:0] cfg_rdata, irq_data, rd, c, m, v;
    logic [31:0] id_v, ca_v, cb_v, sec_v;
    logic [CORE_COUNT*32-1:0] pc_v, sr_v;
    logic [63:0] r64;
    data_access_t da = '0;
    data_access_t x;
    res_access_t ra = '0;
    res_access_t y;
    int seed = 32'h8485;
    int miscompares = 0;
    int checks_done = 0;
    int w, n;
    always #5 clk = ~clk;
    cfg_host host (.clk(clk), .req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
    tile_debug_config_registers dut (.clk(clk), .rst_b(rst_b), .pll_clk_tick(tick),
        .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .identity_value(id_v),
        .counts_a_value(ca_v), .counts_b_value(cb_v), .security_value(sec_v),
        .core_pc_flat(pc_v), .core_sr_flat(sr_v), .debug_mode(dbg), .data_access(da),
        .res_access(ra), .res_cond_a(rca), .res_cond_b(rcb), .debug_irq(debug_irq),
        .irq_cause(irq_cause), .irq_data(irq_data), .tile_clk_en(tile_clk_en));
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input access_source_t s);
        host.xfer(1'b1, s, a, d, rd);
        chk(32'(host.ack_ok), 32'h1, "write ack");
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, SRC_TEST_PORT, a, 32'h0, rd);
        chk(32'(host.ack_ok), 32'h1, "read ack");
        chk(rd, exp, $sformatf("read %h", a));
    endtask
    task automatic ack_irq();
        dbg <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk(32'(debug_irq), 32'h0, "irq cleared");
        dbg <= 1'b0;
    endtask
    task automatic gap(output int k);
        k = 0;
        while (tile_clk_en !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
    endtask
    function automatic logic dhit(logic [31:0] q, data_access_t z);
        return z.valid && q[0] && q[16 + z.thread] && (!z.is_load || q[2])
            && (q[1] ? (z.cond_a || z.cond_b) : (z.cond_a && z.cond_b));
    endfunction
    function automatic logic rhit(logic [31:0] q, logic [31:0] mk, logic [31:0] vl,
        res_access_t z, logic a, logic b);
        return z.valid && q[0] && q[16 + z.thread] && ((z.resource_id & mk) == (vl & mk))
            && (q[1] ? b : a);
    endfunction
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
    initial begin
        id_v = $random(seed);
        ca_v = $random(seed);
        cb_v = $random(seed);
        sec_v = $random(seed);
        for (int i = 0; i < CORE_COUNT; i++) begin
            pc_v[32*i+:32] = $random(seed);
            sr_v[32*i+:32] = $random(seed);
        end
        repeat (12) @(negedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdc(OFS_DATA_WATCH_CTRL + 8'(i), ZERO_WORD);
            rdc(OFS_RES_WATCH_CTRL + 8'(i), ZERO_WORD);
            rdc(OFS_WRITE_PROTECT + 8'(i % 3), ZERO_WORD);
        end
        for (int i = 0; i < 25; i++) begin
            w = i % 8;
            c = $random(seed);
            case (i / 4)
                0: m = DATA_WATCH_CTRL_MASK;
                1: m = 32'hFFFFFFFF;
                2: m = 32'hFFFFFFFF;
                3: m = RES_WATCH_CTRL_MASK;
                default: m = (i == 24) ? CLOCK_DIVIDER_MASK : 32'hFFFFFFFF;
            endcase
            case (i / 4)
                0: n = OFS_DATA_WATCH_CTRL + w % 4;
                1: n = OFS_RES_WATCH_MASK + w % 4;
                2: n = OFS_RES_WATCH_VALUE + w % 4;
                3: n = OFS_RES_WATCH_CTRL + w % 4;
                default: n = (i == 24) ? OFS_CLOCK_DIVIDER : OFS_SCRATCH + w;
            endcase
            wr(8'(n), c, SRC_CORE);
            rdc(8'(n), c & m);
            wr(8'(n), ZERO_WORD, SRC_CORE);
        end
        for (int i = 0; i < 4; i++) begin
            n = (i == 3) ? OFS_SECURITY : i;
            wr(8'(n), $random(seed), SRC_CORE);
        end
        rdc(OFS_IDENTITY, id_v);
        rdc(OFS_COUNTS_A, ca_v & COUNTS_A_MASK);
        rdc(OFS_COUNTS_B, cb_v & COUNTS_B_MASK);
        rdc(OFS_SECURITY, sec_v);
        rdc(8'h03, ZERO_WORD);
        for (int i = 0; i < CORE_COUNT; i++) begin
            wr(OFS_PC_SNAP + 8'(i), $random(seed), SRC_SWITCH);
            rdc(OFS_PC_SNAP + 8'(i), pc_v[32*i+:32]);
            rdc(OFS_SR_SNAP + 8'(i), sr_v[32*i+:32]);
        end
        wr(OFS_WRITE_PROTECT, 32'h1, SRC_CORE);
        wr(OFS_SCRATCH, 32'hA5A5A5A5, SRC_SWITCH);
        rdc(OFS_SCRATCH, ZERO_WORD);
        wr(OFS_SCRATCH, 32'hA5A5A5A5, SRC_CORE);
        rdc(OFS_SCRATCH, 32'hA5A5A5A5);
        wr(OFS_WRITE_PROTECT, 32'hFFFFFFFF, SRC_SWITCH);
        rdc(OFS_WRITE_PROTECT, WRITE_PROTECT_MASK);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_SCRATCH + 8'h1, 32'h5A, access_source_t'(i));
            rdc(OFS_SCRATCH + 8'h1, ZERO_WORD);
        end
        wr(OFS_DATA_WATCH_CTRL, 32'h1, SRC_TEST_PORT);
        rdc(OFS_DATA_WATCH_CTRL, ZERO_WORD);
        wr(OFS_WRITE_PROTECT, ZERO_WORD, SRC_CORE);
        wr(OFS_IRQ_REQUEST, 32'h1, SRC_TEST_PORT);
        @(negedge clk);
        chk(32'(debug_irq), 32'h1, "host irq");
        chk(32'(irq_cause), 32'(CAUSE_HOST), "host cause");
        rdc(OFS_IRQ_TYPE, 32'(CAUSE_HOST));
        rdc(OFS_IRQ_REQUEST, 32'h1);
        dbg <= 1'b1;
        rdc(OFS_IRQ_REQUEST, 32'h2);
        ack_irq();
        for (int i = 0; i < 64; i++) begin
            w = $random(seed) & 3;
            r64 = {$random(seed), $random(seed)};
            x = r64[38:0];
            y = r64[35:0];
            x.valid = 1'b1;
            y.valid = 1'b1;
            c = $random(seed) | ((i % 4 != 0) ? 32'h1 : 32'h0);
            if (i % 3 != 0) begin
                c[16 + x.thread] = 1'b1;
                c[16 + y.thread] = 1'b1;
            end
            m = $random(seed);
            v = $random(seed);
            if (i[0]) begin
                y.resource_id = v ^ ($random(seed) & ~m);
            end
            if (i < 32) begin
                c = c & DATA_WATCH_CTRL_MASK;
                n = OFS_DATA_WATCH_CTRL + w;
                wr(8'(n), c, SRC_CORE);
                da <= x;
                e = dhit(c, x);
            end else begin
                c = c & RES_WATCH_CTRL_MASK;
                n = OFS_RES_WATCH_CTRL + w;
                wr(OFS_RES_WATCH_MASK + 8'(w), m, SRC_CORE);
                wr(OFS_RES_WATCH_VALUE + 8'(w), v, SRC_CORE);
                wr(8'(n), c, SRC_CORE);
                ra <= y;
                rca <= r64[40];
                rcb <= r64[41];
                e = rhit(c, m, v, y, r64[40], r64[41]);
            end
            @(negedge clk);
            da <= '0;
            ra <= '0;
            chk(32'(debug_irq), 32'(e), "watch irq");
            if (e) begin
                chk(32'(irq_cause), (i < 32) ? 32'h4 : 32'h5, "watch cause");
                chk(irq_data, (i < 32) ? x.address : y.resource_id, "irq data");
                rdc(OFS_IRQ_DATA, (i < 32) ? x.address : y.resource_id);
                ack_irq();
            end
            wr(8'(n), ZERO_WORD, SRC_CORE);
        end
        wr(OFS_CLOCK_DIVIDER, 32'h3, SRC_CORE);
        tick <= 1'b1;
        gap(n);
        @(negedge clk);
        gap(n);
        // Period of 3 ticks: one edge was already spent stepping off the pulse
        chk(32'(n), 32'h2, "divided period");
        wr(OFS_CLOCK_DIVIDER, 32'h80000003, SRC_CORE);
        @(negedge clk);
        gap(n);
        chk(32'(n), 32'd40, "stopped clock");
        end_of_test();
    end
endmodule
